/* core/i2c_link_params.svh */
// Constants shared by both ends of the two-wire serial link
`ifndef I2C_LINK_PARAMS_SVH
`define I2C_LINK_PARAMS_SVH

// ============================================================
// Addressing and formats
`define SLAVE_ADDR 7'h32
`define PTR_AFTER_STOP 4'hF
`define FMT_WRITE 4'h0
`define FMT_READ_NOW 4'h4
`define BYTE_BITS 8
`define NUM_REGS 16

// ============================================================
// Timing
`define CLK_PERIOD_NS 25
`define ACCESS_LIMIT_MS 500
`define ACCESS_LIMIT_CYC ((`ACCESS_LIMIT_MS * 1000000) / `CLK_PERIOD_NS)
`define LINK_DIV 4

`endif

/* core/i2c_link_pkg.sv */
// Types shared by both ends of the two-wire serial link
package i2c_link_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] reg_ptr_t;
endpackage

/* core/i2c_link_if.sv */
// Two-wire link joining the master end and the device end
`timescale 1ns/1ps
interface i2c_link_if;
    logic scl_out;
    logic scl_oe;
    logic sda_m_out;
    logic sda_m_oe;
    logic sda_d_out;
    logic sda_d_oe;
    logic scl;
    logic sda;
    // Open-drain wired-and with pull-ups
    assign scl = scl_oe ? scl_out : 1'b1;
    assign sda = (sda_m_oe ? sda_m_out : 1'b1) & (sda_d_oe ? sda_d_out : 1'b1);
    modport master_mp (
        output scl_out, scl_oe, sda_m_out, sda_m_oe,
        input scl, sda
    );
    modport device_mp (
        output sda_d_out, sda_d_oe,
        input scl, sda
    );
endinterface

/* core/rtc_serial_dev.sv */
// Device end: two-wire slave with register pointer and write port
// Functional notes
// - Both lines idle high between transfers
// - SDA falls while SCL high: start
// - SDA rises while SCL high: stop
// - Only master makes start and stop
// - Data changes only while SCL low
// - Eight-bit bytes, each acknowledged by receiver
// - Ack after eighth fall, release at ninth
// - Master nacks last read byte; slave releases
// - First byte: address MSB first, direction
// - Respond only to own address
// - Repeated start resends address
// - Second write byte: pointer and format
// - Master writes format zero
// - Third byte stored at pointer
// - Later bytes increment pointer, wrapping
// - Stop sets pointer to highest
// - Format four reads right after pointer
// - Abandon access after time limit
`timescale 1ns/1ps
`include "i2c_link_params.svh"
module rtc_serial_dev #(
    parameter int ACCESS_CYC = `ACCESS_LIMIT_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link
    i2c_link_if.device_mp link,
    // Register side
    output i2c_link_pkg::reg_ptr_t wr_addr_out,
    output i2c_link_pkg::byte_t wr_data_out,
    output logic wr_en_out,
    output i2c_link_pkg::reg_ptr_t rd_addr_out,
    input wire i2c_link_pkg::byte_t rd_data_in,
    output logic busy_out
);
    import i2c_link_pkg::*;

    typedef enum {
        S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA, S_RACK, S_IGNORE
    } dev_state_t;

    // ============================================================
    // Pin synchronisers
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q, scl_p_q, sda_p_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= link.scl;
            scl_s_q <= scl_m_q;
            sda_m_q <= link.sda;
            sda_s_q <= sda_m_q;
            scl_p_q <= scl_s_q;
            sda_p_q <= sda_s_q;
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_seen = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_seen = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // ============================================================
    // Access timer
    logic [$clog2(ACCESS_CYC+1)-1:0] tmr_q;
    logic timeout;
    assign timeout = busy_out && (tmr_q == ($bits(tmr_q))'(ACCESS_CYC));
    always_ff @(posedge clk_in) begin
        if (rst_in || stop_seen || timeout)
            tmr_q <= '0;
        else if (busy_out)
            tmr_q <= tmr_q + 1'b1;
    end

    // ============================================================
    // Byte engine
    dev_state_t state_q;
    logic [3:0] bit_q;
    byte_t sh_q;
    reg_ptr_t ptr_q;
    logic ack_q;
    logic first_q;
    logic tx_q;
    logic in_ack;
    logic byte_end;
    logic ack_end;
    assign in_ack = (bit_q == 4'd8);
    assign byte_end = scl_fall && !in_ack && (bit_q == 4'd7);
    assign ack_end = scl_fall && in_ack;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= S_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            ptr_q <= `PTR_AFTER_STOP;
            ack_q <= 1'b0;
            tx_q <= 1'b0;
            first_q <= 1'b0;
        end else if (stop_seen || timeout) begin
            state_q <= S_IDLE;
            ptr_q <= `PTR_AFTER_STOP;
            ack_q <= 1'b0;
            tx_q <= 1'b0;
        end else if (start_seen) begin
            state_q <= S_ADDR;
            bit_q <= 4'hF;
            ack_q <= 1'b0;
            tx_q <= 1'b0;
        end else if (state_q == S_IDLE) begin
            bit_q <= '0;
        end else if (scl_rise && !in_ack && !tx_q) begin
            sh_q <= {sh_q[6:0], sda_s_q};
        end else if (scl_rise && in_ack && state_q == S_RACK) begin
            if (sda_s_q)
                state_q <= S_IGNORE;
        end else if (ack_end) begin
            bit_q <= '0;
            ack_q <= 1'b0;
            if (state_q == S_RACK) begin
                state_q <= S_RDATA;
                tx_q <= 1'b1;
                sh_q <= rd_data_in;
                ptr_q <= ptr_q + 1'b1;
            end
        end else if (byte_end) begin
            bit_q <= 4'd8;
            tx_q <= 1'b0;
            case (state_q)
                S_ADDR: begin
                    if (sh_q[7:1] == `SLAVE_ADDR) begin
                        ack_q <= 1'b1;
                        state_q <= sh_q[0] ? S_RACK : S_PTR;
                        first_q <= 1'b1;
                    end else begin
                        state_q <= S_IGNORE;
                    end
                end
                S_PTR: begin
                    ack_q <= 1'b1;
                    ptr_q <= sh_q[7:4];
                    if (sh_q[3:0] == `FMT_READ_NOW)
                        state_q <= S_RACK;
                    else
                        state_q <= S_WDATA;
                end
                S_WDATA: begin
                    ack_q <= 1'b1;
                    if (!first_q)
                        ptr_q <= ptr_q + 1'b1;
                    first_q <= 1'b0;
                end
                S_RDATA: state_q <= S_RACK;
                default: state_q <= S_IGNORE;
            endcase
        end else if (scl_fall) begin
            bit_q <= bit_q + 1'b1;
            if (tx_q)
                sh_q <= {sh_q[6:0], 1'b0};
        end
    end

    // ============================================================
    // Register write port
    logic wr_now;
    assign wr_now = byte_end && !timeout && (state_q == S_WDATA);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_en_out <= 1'b0;
            wr_addr_out <= '0;
            wr_data_out <= '0;
        end else begin
            wr_en_out <= wr_now;
            if (wr_now) begin
                wr_addr_out <= first_q ? ptr_q : ptr_q + 1'b1;
                wr_data_out <= sh_q;
            end
        end
    end

    // ============================================================
    // Access flag
    always_ff @(posedge clk_in) begin
        if (rst_in || stop_seen || timeout)
            busy_out <= 1'b0;
        else if (start_seen)
            busy_out <= 1'b1;
    end

    // Read address: register loaded at the next acknowledge fall
    assign rd_addr_out = ptr_q;

    // ============================================================
    // SDA drive, changed only after SCL falls
    assign link.sda_d_out = 1'b0;
    assign link.sda_d_oe = ack_q | (tx_q & ~sh_q[7]);
endmodule // rtc_serial_dev

/* core/i2c_host_end.sv */
// Master end: generates clock, start, stop and bytes
`timescale 1ns/1ps
`include "i2c_link_params.svh"
module i2c_host_end #(
    parameter int DIV = `LINK_DIV
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Command port
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic byte_in,
    input wire logic read_in,
    input wire logic last_in,
    input wire i2c_link_pkg::byte_t data_in,
    output logic ready_out,
    output i2c_link_pkg::byte_t data_out,
    output logic ack_out,
    output logic done_out,
    // Link
    i2c_link_if.master_mp link
);
    import i2c_link_pkg::*;

    typedef enum {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;

    // ============================================================
    // Synchronisers for the returned SDA line
    logic sda_m_q, sda_s_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            sda_m_q <= link.sda;
            sda_s_q <= sda_m_q;
        end
    end

    // ============================================================
    // Sequencer: each bit is four phases of DIV cycles
    host_state_t st_q;
    logic [7:0] cnt_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    byte_t sh_q;
    logic rd_q, last_q, scl_q, sda_q;
    wire tick = (cnt_q == 8'(DIV - 1));

    assign ready_out = (st_q == H_IDLE);
    assign link.scl_out = 1'b0;
    assign link.scl_oe = ~scl_q;
    assign link.sda_m_out = 1'b0;
    assign link.sda_m_oe = ~sda_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= H_IDLE;
            cnt_q <= '0;
            ph_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            rd_q <= 1'b0;
            last_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            data_out <= '0;
            ack_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            cnt_q <= tick ? 8'd0 : cnt_q + 8'd1;
            case (st_q)
                H_IDLE: begin
                    cnt_q <= '0;
                    ph_q <= '0;
                    if (start_in)
                        st_q <= H_START;
                    else if (stop_in)
                        st_q <= H_STOP;
                    else if (byte_in) begin
                        st_q <= H_BIT;
                        bit_q <= '0;
                        rd_q <= read_in;
                        last_q <= last_in;
                        sh_q <= read_in ? 8'hFF : data_in;
                    end
                end
                H_START: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    case (ph_q)
                        2'd0: sda_q <= 1'b1;
                        2'd1: scl_q <= 1'b1;
                        2'd2: sda_q <= 1'b0;
                        default: begin
                            scl_q <= 1'b0;
                            st_q <= H_IDLE;
                            done_out <= 1'b1;
                        end
                    endcase
                end
                H_STOP: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    case (ph_q)
                        2'd0: sda_q <= 1'b0;
                        2'd1: scl_q <= 1'b1;
                        2'd2: sda_q <= 1'b1;
                        default: begin
                            st_q <= H_IDLE;
                            done_out <= 1'b1;
                        end
                    endcase
                end
                H_BIT: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    case (ph_q)
                        2'd0: begin
                            if (bit_q == 4'd8)
                                sda_q <= rd_q ? last_q : 1'b1;
                            else
                                sda_q <= sh_q[7];
                        end
                        2'd1: scl_q <= 1'b1;
                        2'd2: begin
                            if (bit_q == 4'd8)
                                ack_out <= ~sda_s_q;
                            else
                                sh_q <= {sh_q[6:0], sda_s_q};
                        end
                        default: begin
                            scl_q <= 1'b0;
                            if (bit_q == 4'd8) begin
                                st_q <= H_IDLE;
                                done_out <= 1'b1;
                                data_out <= sh_q;
                                sda_q <= 1'b1;
                            end
                            bit_q <= bit_q + 4'd1;
                        end
                    endcase
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule // i2c_host_end

/* dv/rtc_i2c_slave_write_port_monitor.sv */
// Checker for the two-wire link between master and device ends
`timescale 1ns/1ps
module rtc_i2c_slave_write_port_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe,
    input wire logic sda_d_oe
);
    logic [3:0] bit_q;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // ============================================================
    // Clock pulses since the last start, modulo one byte frame
    always_ff @(posedge clk_in) begin
        if (rst_in || ($fell(sda) && scl && $past(scl))) begin
            bit_q <= 4'h0;
        end else if ($rose(scl)) begin
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        end
    end
    // ============================================================
    // Assertions
    idle_after_reset_a: assert property ($fell(rst_in) |-> scl && sda)
        else $error("link not idle after reset");
    start_master_a: assert property ($fell(sda) && scl && $past(scl)
        |-> sda_m_oe && !sda_d_oe) else $error("start not from master");
    stop_master_a: assert property ($rose(sda) && scl && $past(scl)
        |-> !$past(sda_d_oe)) else $error("stop not from master");
    stop_idle_a: assert property ($rose(sda) && scl && $past(scl)
        |=> (scl && sda && !sda_d_oe) [*4]) else $error("not idle");
    dev_stable_a: assert property (scl && $past(scl)
        |-> $stable(sda_d_oe)) else $error("device changed data at high");
    dev_low_edge_a: assert property ($rose(sda_d_oe) |-> !scl)
        else $error("device drove while clock high");
    ack_hold_a: assert property ($rose(sda_d_oe)
        |-> sda_d_oe throughout (##[1:24] $rose(scl)))
        else $error("device bit not held to clock high");
    dev_release_a: assert property ($fell(sda_d_oe)
        |-> !scl && !$past(scl)) else $error("device released at high");
    stop_frame_a: assert property ($rose(sda) && scl && $past(scl)
        |-> bit_q == 4'h1) else $error("stop inside a byte");
    // ============================================================
    // Coverage
    start_c: cover property ($fell(sda) && scl && $past(scl));
    ack_c: cover property ($rose(sda_d_oe));
    stop_c: cover property ($rose(sda) && scl && $past(scl));
endmodule // rtc_i2c_slave_write_port_monitor

/* dv/test_rtc_i2c_slave_write_port.sv */
// Self-checking bench joining the master and device ends
`timescale 1ns/1ps
`include "i2c_link_params.svh"
module test_rtc_i2c_slave_write_port;
    import i2c_link_pkg::*;
    localparam int ACC = 2000;
    logic clk_in, rst_in, start_in, stop_in, byte_in, read_in, last_in;
    logic ready_out, ack_out, done_out, wr_en_out, busy_out;
    byte_t data_in, data_out, wr_data_out, rd_data_in;
    reg_ptr_t wr_addr_out, rd_addr_out, p;
    byte_t regs [16];
    byte_t shadow [16];
    logic [9:0] host_q [$];
    logic [11:0] wr_q [$];
    int n_mismatch = 0;
    int num_checks = 0;
    i2c_link_if link_if ();
    i2c_host_end i2c_host_end_inst (.clk_in(clk_in), .rst_in(rst_in),
        .start_in(start_in), .stop_in(stop_in), .byte_in(byte_in),
        .read_in(read_in), .last_in(last_in), .data_in(data_in),
        .ready_out(ready_out), .data_out(data_out), .ack_out(ack_out),
        .done_out(done_out), .link(link_if.master_mp));
    rtc_serial_dev #(.ACCESS_CYC(ACC)) rtc_serial_dev_inst (
        .clk_in(clk_in), .rst_in(rst_in), .link(link_if.device_mp),
        .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
        .wr_en_out(wr_en_out), .rd_addr_out(rd_addr_out),
        .rd_data_in(rd_data_in), .busy_out(busy_out));
    rtc_i2c_slave_write_port_monitor rtc_i2c_slave_write_port_monitor_inst (
        .clk_in(clk_in), .rst_in(rst_in), .scl(link_if.scl),
        .sda(link_if.sda), .sda_m_oe(link_if.sda_m_oe),
        .sda_d_oe(link_if.sda_d_oe));
    assign rd_data_in = regs[rd_addr_out];
    always @(posedge clk_in) begin
        if (wr_en_out === 1'b1) regs[wr_addr_out] <= wr_data_out;
    end
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // ============================================================
    // Report, compare and command tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: exp %0h got %0h", $time, exp, got);
        end
    endtask
    task automatic cmd(input logic [9:0] note, input logic [4:0] c,
                       input byte_t d);
        int i;
        i = 0;
        host_q.push_back(note);
        while (ready_out !== 1'b1 && i < 4000) begin
            @(posedge clk_in);
            #2;
            i++;
        end
        {start_in, stop_in, byte_in, read_in, last_in} = c;
        data_in = d;
        @(posedge clk_in);
        #2;
        {start_in, stop_in, byte_in} = 3'b000;
        while (done_out !== 1'b1 && i < 4000) begin
            @(posedge clk_in);
            #2;
            i++;
        end
        if (i >= 4000) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic sel(input logic rw, input logic [6:0] a, input logic k);
        cmd(10'h000, 5'b10000, 8'h00);
        cmd({9'h080, k}, 5'b00100, {a, rw});
    endtask
    task automatic rd(input int n);
        for (int k = 0; k < n; k++) begin
            cmd({2'b10, shadow[p]}, {4'b0011, k == n - 1}, 8'h00);
            p = p + 4'h1;
        end
    endtask
    // ============================================================
    // Result watcher
    initial begin
        logic [9:0] n;
        forever begin
            @(posedge clk_in);
            if (done_out === 1'b1) begin
                n = (host_q.size() > 0) ? host_q.pop_front() : 10'h3FF;
                if (n[9:8] == 2'b01)
                    cmp({11'h0, n[0]}, {11'h0, ack_out});
                if (n[9] == 1'b1)
                    cmp({4'h0, n[7:0]}, {4'h0, data_out});
            end
            if (wr_en_out === 1'b1) begin
                cmp((wr_q.size() > 0) ? wr_q.pop_front() : 12'hXXX,
                    {wr_addr_out, wr_data_out});
            end
        end
    end
    // ============================================================
    // Main sequence
    initial begin
        byte_t d;
        void'($urandom(57));
        for (int k = 0; k < 16; k++) begin
            regs[k] = byte_t'($urandom);
            shadow[k] = regs[k];
        end
        {start_in, stop_in, byte_in, read_in, last_in} = 5'b00000;
        data_in = 8'h00;
        rst_in = 1'b1;
        repeat (16) @(posedge clk_in);
        #2;
        rst_in = 1'b0;
        @(posedge clk_in);
        #2;
        cmp(12'h003, {10'h0, link_if.scl, link_if.sda});
        sel(1'b0, `SLAVE_ADDR, 1'b1);
        p = 4'hE;
        cmd(10'h101, 5'b00100, {p, `FMT_WRITE});
        for (int k = 0; k < 4; k++) begin
            d = byte_t'($urandom);
            shadow[p] = d;
            wr_q.push_back({p, d});
            cmd(10'h101, 5'b00100, d);
            p = p + 4'h1;
        end
        cmd(10'h000, 5'b01000, 8'h00);
        cmp(12'h000, {11'h0, busy_out});
        $display("test write_wrap done");
        sel(1'b0, 7'h33, 1'b0);
        cmd(10'h100, 5'b00100, 8'h5A);
        cmd(10'h000, 5'b01000, 8'h00);
        $display("test foreign_address done");
        sel(1'b0, `SLAVE_ADDR, 1'b1);
        p = 4'hE;
        cmd(10'h101, 5'b00100, {p, `FMT_READ_NOW});
        rd(3);
        cmd(10'h000, 5'b01000, 8'h00);
        $display("test read_now done");
        sel(1'b1, `SLAVE_ADDR, 1'b1);
        p = `PTR_AFTER_STOP;
        rd(2);
        cmd(10'h000, 5'b01000, 8'h00);
        $display("test read_after_stop done");
        sel(1'b0, `SLAVE_ADDR, 1'b1);
        p = 4'h3;
        cmd(10'h101, 5'b00100, {p, `FMT_WRITE});
        sel(1'b1, `SLAVE_ADDR, 1'b1);
        rd(2);
        cmd(10'h000, 5'b01000, 8'h00);
        $display("test repeated_start done");
        sel(1'b0, `SLAVE_ADDR, 1'b1);
        cmd(10'h101, 5'b00100, {4'h5, `FMT_WRITE});
        repeat (2 * ACC + 100) @(posedge clk_in);
        #2;
        cmp(12'h000, {11'h0, busy_out});
        sel(1'b1, `SLAVE_ADDR, 1'b1);
        p = `PTR_AFTER_STOP;
        rd(1);
        cmd(10'h000, 5'b01000, 8'h00);
        $display("test access_timeout done");
        repeat (20) @(posedge clk_in);
        cmp(12'h000, 12'(host_q.size() + wr_q.size()));
        end_sim();
    end
endmodule // test_rtc_i2c_slave_write_port
